// *** logic/mqf_flags.sv ***
`timescale 1ns/100ps
`include "mqf_map.svh"

module mqf_flags
  import mqf_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Queue ports and strap
  input  wire mqf_port_t   wr_port,
  input  wire mqf_port_t   rd_port,
  input  wire logic        default_offset_select,
  // Flags
  output logic             output_valid_n,
  output logic             full_flag_n,
  output logic             active_almost_empty_n,
  output logic             active_almost_full_n,
  output logic [3:0]       almost_empty_status_bus,
  output logic [3:0]       almost_full_status_bus
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Boundary in storage units: the fall-through bonus is dropped for
  // 18-in/9-out, and the count doubles unless both widths match
  function automatic logic [17:0] f_thr(mqf_mode_t md, logic [16:0] x, logic s);
    logic [17:0] b;
    b = {1'b0, x} + ((md == MQF_I18O9) ? 18'h00000 : {17'h00000, s});
    f_thr = (md == MQF_EQ) ? b : {b[16:0], 1'b0};
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] f_merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    f_merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        f_merge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  mqf_mode_t   mode_ff;
  logic [16:0] depth_ff;
  logic [16:0] aeoff_ff;
  logic [16:0] afoff_ff;
  logic [17:0] lvl_ff [MQF_NQ];
  logic [3:0]  sh_ff;
  logic        valid_n_ff;
  logic        full_n_ff;
  logic        act_ae_n_ff;
  logic        act_ae_d1_ff;
  logic        act_af_n_ff;
  logic        act_af_d1_ff;
  logic [3:0]  aeb_ff;
  logic [3:0]  aeb_d1_ff;
  logic [3:0]  afb_ff;
  logic [3:0]  afb_d1_ff;

  // ************************************************************
  // Queue occupancy
  // ************************************************************
  logic [17:0] nxt_lvl [MQF_NQ];
  logic [3:0]  nxt_sh;
  logic [3:0]  fl_w;
  logic [3:0]  nxt_fl_w;
  logic [3:0]  ae_now_w;
  logic [3:0]  af_now_w;
  wire  [17:0] wmul = (mode_ff == MQF_I18O9) ? `MQF_U2 : `MQF_U1;
  wire  [17:0] rmul = (mode_ff == MQF_I9O18) ? `MQF_U2 : `MQF_U1;
  wire  [16:0] ae_base = aeoff_ff + `MQF_OFF_ONE;
  wire  [16:0] af_base = depth_ff - afoff_ff;
  wire         af_bonus_all = (mode_ff == MQF_I9O18);

  // Writes to a full queue and reads of an empty one are dropped
  wire wr_ok = wr_port.en && !fl_w[wr_port.q];
  wire rd_ok = rd_port.en && (lvl_ff[rd_port.q] >= rmul);

  // Levels count 9-bit units so every width setup shares one counter
  for (genvar q = 0; q < MQF_NQ; q++)
  begin : g_q
    wire         wh = wr_ok && (wr_port.q == 2'(q));
    wire         rh = rd_ok && (rd_port.q == 2'(q));
    wire         first = wh && (lvl_ff[q] == '0);
    // Read port on the queue at the first write means a word falls through
    assign nxt_sh[q]   = first ? (rd_port.q == 2'(q)) : sh_ff[q];
    assign nxt_lvl[q]  = lvl_ff[q] + (wh ? wmul : '0) - (rh ? rmul : '0);
    assign fl_w[q]     = lvl_ff[q] >= f_thr(mode_ff, depth_ff, sh_ff[q]);
    assign nxt_fl_w[q] = nxt_lvl[q] >= f_thr(mode_ff, depth_ff, nxt_sh[q]);
    assign ae_now_w[q] = lvl_ff[q] >= f_thr(mode_ff, ae_base, sh_ff[q]);
    assign af_now_w[q] = !(lvl_ff[q] >= f_thr(mode_ff, af_base,
                           af_bonus_all | sh_ff[q]));
  end

  // Levels and fall-through marks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_ff <= '0;
      for (int i = 0; i < MQF_NQ; i++)
        lvl_ff[i] <= '0;
    end
    else
    begin
      sh_ff <= nxt_sh;
      for (int i = 0; i < MQF_NQ; i++)
        lvl_ff[i] <= nxt_lvl[i];
    end
  end

  // ************************************************************
  // Discrete active-queue flags
  // ************************************************************
  wire rq_lo     = lvl_ff[rd_port.q] < rmul;
  wire rq_lo_nxt = nxt_lvl[rd_port.q] < rmul;
  wire wq_fill   = wr_ok && nxt_fl_w[wr_port.q];
  wire ae_act_w  = ae_now_w[rd_port.q];
  wire af_act_w  = af_now_w[wr_port.q];
  // Valid needs a word both now and after this edge's read
  wire nxt_valid_n = rq_lo || rq_lo_nxt;
  // Falls with the filling write, rises one edge after the read frees room
  wire nxt_full_n = !wq_fill && !fl_w[wr_port.q];

  // Active flags: one stage for the releasing edge, two for the asserting one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      valid_n_ff   <= 1'b1;
      full_n_ff    <= 1'b1;
      act_ae_d1_ff <= 1'b0;
      act_ae_n_ff  <= 1'b0;
      act_af_d1_ff <= 1'b1;
      act_af_n_ff  <= 1'b1;
    end
    else
    begin
      valid_n_ff   <= nxt_valid_n;
      full_n_ff    <= nxt_full_n;
      act_ae_d1_ff <= ae_act_w;
      act_ae_n_ff  <= ae_act_w | act_ae_d1_ff;
      act_af_d1_ff <= af_act_w;
      act_af_n_ff  <= af_act_w | act_af_d1_ff;
    end
  end

  // ************************************************************
  // Status buses
  // ************************************************************
  // Bit k follows queue k whatever either port selects; a queue
  // switch cannot stretch these, but the tolerated extra cycle still shows on each asserting edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aeb_d1_ff <= '0;
      aeb_ff    <= '0;
      afb_d1_ff <= '1;
      afb_ff    <= '1;
    end
    else
    begin
      aeb_d1_ff <= ae_now_w;
      aeb_ff    <= ae_now_w | aeb_d1_ff;
      afb_d1_ff <= af_now_w;
      afb_ff    <= af_now_w | afb_d1_ff;
    end
  end

  assign output_valid_n          = valid_n_ff;
  assign full_flag_n             = full_n_ff;
  assign active_almost_empty_n   = act_ae_n_ff;
  assign active_almost_full_n    = act_af_n_ff;
  assign almost_empty_status_bus = aeb_ff;
  assign almost_full_status_bus  = afb_ff;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // Address and data are caught separately, in either order
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready  = !w_hold_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  wire wr_do  = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire sel_c  = awaddr_ff == `MQF_ADDR_CTRL;
  wire sel_d  = awaddr_ff == `MQF_ADDR_DEPTH;
  wire sel_e  = awaddr_ff == `MQF_ADDR_AEOFF;
  wire sel_f  = awaddr_ff == `MQF_ADDR_AFOFF;
  wire wr_hit = sel_c || sel_d || sel_e || sel_f;
  wire [31:0] m_ctrl  = f_merge(32'(mode_ff), wdata_ff, wstrb_ff);
  wire [31:0] m_depth = f_merge(32'(depth_ff), wdata_ff, wstrb_ff);
  wire [31:0] m_aeoff = f_merge(32'(aeoff_ff), wdata_ff, wstrb_ff);
  wire [31:0] m_afoff = f_merge(32'(afoff_ff), wdata_ff, wstrb_ff);
  // An unused mode code would mis-scale every boundary, so it is ignored
  wire mode_legal = m_ctrl[1:0] != 2'b11;

  // Read selection; status and level show live block state
  wire ar_do = s_axi_arvalid && !rvalid_ff;
  wire [31:0] stat_w = {20'h00000, afb_ff, aeb_ff,
                        act_af_n_ff, act_ae_n_ff, full_n_ff, valid_n_ff};
  wire rd_hit = (s_axi_araddr == `MQF_ADDR_CTRL) || (s_axi_araddr == `MQF_ADDR_DEPTH)
             || (s_axi_araddr == `MQF_ADDR_AEOFF) || (s_axi_araddr == `MQF_ADDR_AFOFF)
             || (s_axi_araddr == `MQF_ADDR_STAT) || (s_axi_araddr == `MQF_ADDR_LEVEL);
  wire [31:0] rd_val =
      (s_axi_araddr == `MQF_ADDR_CTRL)  ? 32'(mode_ff)  :
      (s_axi_araddr == `MQF_ADDR_DEPTH) ? 32'(depth_ff) :
      (s_axi_araddr == `MQF_ADDR_AEOFF) ? 32'(aeoff_ff) :
      (s_axi_araddr == `MQF_ADDR_AFOFF) ? 32'(afoff_ff) :
      (s_axi_araddr == `MQF_ADDR_STAT)  ? stat_w        :
      (s_axi_araddr == `MQF_ADDR_LEVEL) ? 32'(lvl_ff[rd_port.q]) : 32'h00000000;

  // Write channel bookkeeping
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `MQF_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_ff)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_ff)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? `MQF_RESP_OK : `MQF_RESP_ERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Control registers; offsets take their default from the strap at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_ff  <= MQF_EQ;
      depth_ff <= `MQF_DEPTH_RST;
      aeoff_ff <= default_offset_select ? `MQF_OFF_HIGH : `MQF_OFF_LOW;
      afoff_ff <= default_offset_select ? `MQF_OFF_HIGH : `MQF_OFF_LOW;
    end
    else if (wr_do)
    begin
      if (sel_c && mode_legal)
        mode_ff <= mqf_mode_t'(m_ctrl[1:0]);
      if (sel_d)
        depth_ff <= m_depth[16:0];
      if (sel_e)
        aeoff_ff <= m_aeoff[16:0];
      if (sel_f)
        afoff_ff <= m_afoff[16:0];
    end
  end

  // Read channel; data is held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= `MQF_RESP_OK;
    end
    else if (ar_do)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_hit ? `MQF_RESP_OK : `MQF_RESP_ERR;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Edges of the active flags are judged only while the port keeps its queue
  property p_valid_low;
    (rq_lo && !rq_lo_nxt) ##1 ($stable(rd_port.q) && !rd_port.en) |=> !output_valid_n;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("valid late after write");

  property p_valid_high;
    (rd_ok && rq_lo_nxt) |=> output_valid_n;
  endproperty
  a_valid_high: assert property (p_valid_high) else $error("valid held after last read");

  property p_full_set;
    wq_fill |=> !full_flag_n ##1 (!full_flag_n || !$stable(wr_port.q) || !fl_w[wr_port.q]);
  endproperty
  a_full_set: assert property (p_full_set) else $error("full missed filling write");

  property p_full_rel;
    (!fl_w[wr_port.q] && $past(fl_w[wr_port.q]) && $stable(wr_port.q) && !wq_fill)
      |-> !full_flag_n ##1 full_flag_n;
  endproperty
  a_full_rel: assert property (p_full_rel) else $error("full release timing");

  property p_full_lvl;
    (wr_port.en && !full_flag_n && $stable(wr_port.q) && $past(!wq_fill)) |-> !wr_ok;
  endproperty
  a_full_lvl: assert property (p_full_lvl) else $error("write taken while full");

  property p_def_off;
    $rose(aresetn) |-> (aeoff_ff == afoff_ff)
      && (aeoff_ff == ($past(default_offset_select) ? `MQF_OFF_HIGH : `MQF_OFF_LOW));
  endproperty
  a_def_off: assert property (p_def_off) else $error("default offset wrong");

  property p_act_ae_low;
    (!ae_act_w && $past(ae_act_w) && $stable(rd_port.q)) ##1 (!ae_act_w && $stable(rd_port.q))
      |-> $past(active_almost_empty_n) ##1 !active_almost_empty_n;
  endproperty
  a_act_ae_low: assert property (p_act_ae_low) else $error("almost empty fall timing");

  property p_act_ae_high;
    (ae_act_w && !$past(ae_act_w) && $stable(rd_port.q)) |=> active_almost_empty_n;
  endproperty
  a_act_ae_high: assert property (p_act_ae_high) else $error("almost empty rise late");

  property p_act_af_low;
    (!af_act_w && $past(af_act_w) && $stable(wr_port.q)) ##1 (!af_act_w && $stable(wr_port.q))
      |=> !active_almost_full_n;
  endproperty
  a_act_af_low: assert property (p_act_af_low) else $error("almost full fall timing");

  property p_act_af_high;
    (af_act_w && !$past(af_act_w) && $stable(wr_port.q)) |=> active_almost_full_n;
  endproperty
  a_act_af_high: assert property (p_act_af_high) else $error("almost full rise late");

  // The delay stage keeps the bit high for one more edge after the crossing
  property p_aeb;
    (!ae_now_w[0] && $past(ae_now_w[0])) ##1 !ae_now_w[0] |->
      $past(almost_empty_status_bus[0]) && almost_empty_status_bus[0] ##1
      !almost_empty_status_bus[0];
  endproperty
  a_aeb: assert property (p_aeb) else $error("status empty bit timing");

  property p_afb;
    (af_now_w[3] && !$past(af_now_w[3])) |=> almost_full_status_bus[3];
  endproperty
  a_afb: assert property (p_afb) else $error("status full bit rise late");

endmodule

// *** logic/mqf_map.svh ***
`ifndef MQF_MAP_SVH
`define MQF_MAP_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define MQF_ADDR_CTRL  8'h00
`define MQF_ADDR_DEPTH 8'h04
`define MQF_ADDR_AEOFF 8'h08
`define MQF_ADDR_AFOFF 8'h0C
`define MQF_ADDR_STAT  8'h10
`define MQF_ADDR_LEVEL 8'h14

// ************************************************************
// Reset values and unit steps
// ************************************************************
`define MQF_DEPTH_RST  17'h02000
`define MQF_OFF_LOW    17'h00008
`define MQF_OFF_HIGH   17'h00080
`define MQF_OFF_ONE    17'h00001
`define MQF_U1         18'h00001
`define MQF_U2         18'h00002

// ************************************************************
// Bus answers
// ************************************************************
`define MQF_RESP_OK    2'h0
`define MQF_RESP_ERR   2'h2

`endif

// *** logic/mqf_pkg.sv ***
package mqf_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int MQF_NQ = 4;

  // ************************************************************
  // Types
  // ************************************************************
  // Bus matching setup, common to all queues
  typedef enum logic [1:0]
  {
    MQF_EQ    = 2'b00,
    MQF_I18O9 = 2'b01,
    MQF_I9O18 = 2'b10
  } mqf_mode_t;

  // One queue port: an operation strobe and the queue it targets
  typedef struct packed
  {
    logic       en;
    logic [1:0] q;
  } mqf_port_t;

endpackage

// *** test/mqf_host.sv ***
`timescale 1ns/100ps

// ********************************
// Host logic on the queue ports
// ********************************
module mqf_host
  import mqf_pkg::*;
(
  // Clock
  input  wire logic aclk,
  // Queue ports toward the device
  output mqf_port_t wr_port,
  output mqf_port_t rd_port
);
  // Idle ports from time zero so no strobe is seen as unknown
  initial
  begin
    wr_port = '0;
    rd_port = '0;
  end

  // Queue selects; set only between bursts, never during one
  task sel(input logic [1:0] wq, input logic [1:0] rq);
    wr_port.q <= wq;
    rd_port.q <= rq;
  endtask

  // One strobe pair per edge, changed just after the edge
  task drive(input logic w, input logic r);
    wr_port.en <= w;
    rd_port.en <= r;
  endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/100ps
`include "mqf_map.svh"

module tb
  import mqf_pkg::*;
;
  localparam int D = 4;
  localparam int M = 1;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        strap = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        valid_n, full_n, ae_n, af_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  ae_bus, af_bus;
  mqf_port_t   wr_port, rd_port;
  logic [33:0] exp_q[$];
  logic [1:0]  exp_b[$];
  int          mismatches = 0;
  int          n_tests = 0;
  int          h0, h1, h2, tfu, tae, taf, n, q, rq, k, s;
  logic        pw, pr, sh, io;
  logic [31:0] seed = 32'h9AEC;

  // ********************************
  // Clock, device and host
  // ********************************
  always #50 aclk = ~aclk;

  mqf_flags dut_u
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wr_port(wr_port), .rd_port(rd_port), .default_offset_select(strap),
    .output_valid_n(valid_n), .full_flag_n(full_n),
    .active_almost_empty_n(ae_n), .active_almost_full_n(af_n),
    .almost_empty_status_bus(ae_bus), .almost_full_status_bus(af_bus)
  );

  mqf_host host_u
  (
    .aclk(aclk),
    .wr_port(wr_port),
    .rd_port(rd_port)
  );

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Strap is sampled while reset is low, so it changes with it
  task rst(input logic st, input int c);
    @(posedge aclk);
    aresetn <= 1'h0;
    strap <= st;
    repeat (c) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  // Ready is looked at on the falling edge, where it has settled
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // Only the four writable registers answer OK
    exp_b.push_back((a <= `MQF_ADDR_AFOFF) ? `MQF_RESP_OK : `MQF_RESP_ERR);
    do
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
    end while ((awvalid & ~ta) | (wvalid & ~tw));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'h0;
  endtask

  task axr(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'h0;
    exp_q.push_back(e);
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'h0;
  endtask

  // Read answers are judged in order of request
  always @(posedge aclk)
    if (rvalid && rready && exp_q.size() > 0)
      check("rdata", {rresp, rdata}, exp_q.pop_front());

  // Write answers, likewise in order
  always @(posedge aclk)
    if (bvalid && bready && exp_b.size() > 0)
      check("bresp", bresp, exp_b.pop_front());

  // One edge: drive the next strobes, model the sampled ones, compare
  task step(input logic w, input logic r);
    logic [3:0] ea, ef;
    @(posedge aclk);
    host_u.drive(w, r);
    h2 = h1;
    h1 = h0;
    if (pw && h0 < tfu)
      h0++;
    if (pr && h0 > 0)
      h0--;
    pw = w;
    pr = r;
    #1;
    ea = (h1 >= tae || h2 >= tae) ? 4'h1 << q : 4'h0;
    ef = (h1 >= taf && h2 >= taf) ? ~(4'h1 << q) : 4'hF;
    check("full", full_n, !(h0 >= tfu || h1 >= tfu));
    check("ae_bus", ae_bus, ea);
    check("af_bus", af_bus, ef);
    check("af_n", af_n, ef[q]);
    check("ae_n", ae_n, ea[rq] & sh);
    // A word is presented once a whole read unit has stood for two edges
    check("valid_n", valid_n, !(sh && h0 >= k && h1 >= k));
  endtask

  // One setup: fill past full, idle, and drain the plain shared case
  task run(input int i);
    int md;
    logic [31:0] r;
    md = i / 2;
    sh = (i % 2) == 0;
    io = md == 2;
    r = rnd();
    q = r[1:0];
    n = 1 + r[2];
    rq = sh ? q : q ^ 1;
    k = io ? 2 : 1;
    s = sh && md != 1;
    tfu = k * (D + s);
    tae = k * (n + 1 + s);
    taf = k * (D + (io ? 1 : s) - M);
    h0 = 0;
    h1 = 0;
    h2 = 0;
    pw = 1'h0;
    pr = 1'h0;
    rst(r[3], 2);
    axw(`MQF_ADDR_CTRL, 32'(md), 4'hF);
    axw(`MQF_ADDR_DEPTH, 32'(D), 4'hF);
    axw(`MQF_ADDR_AEOFF, 32'(n), 4'hF);
    // Upper lanes carry noise that a disabled strobe must keep out
    axw(`MQF_ADDR_AFOFF, {r[31:8], 8'h01}, 4'h1);
    @(posedge aclk);
    host_u.sel(2'(q), 2'(rq));
    repeat (tfu + 3) step(1'h1, 1'h0);
    repeat (3) step(1'h0, 1'h0);
    // Level of the read queue in 9-bit units; an 18-bit write counts twice
    axr(`MQF_ADDR_LEVEL, {`MQF_RESP_OK, 32'(sh ? h0 * (md == 1 ? 2 : 1) : 0)});
    if (i == 0)
      repeat (tfu + 3) step(1'h0, 1'h1);
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    rst(1'h0, 12);
    axr(`MQF_ADDR_AEOFF, {17'h0, `MQF_OFF_LOW});
    axr(`MQF_ADDR_AFOFF, {17'h0, `MQF_OFF_LOW});
    axr(`MQF_ADDR_DEPTH, {17'h0, `MQF_DEPTH_RST});
    axr(8'h18, {`MQF_RESP_ERR, 32'h0});
    rst(1'h1, 2);
    axr(`MQF_ADDR_AEOFF, {17'h0, `MQF_OFF_HIGH});
    axr(`MQF_ADDR_AFOFF, {17'h0, `MQF_OFF_HIGH});
    // Idle flags after reset, an unused mode code and a write to no register
    axr(`MQF_ADDR_STAT, {`MQF_RESP_OK, 32'h00000F0B});
    axw(`MQF_ADDR_CTRL, 32'h00000003, 4'hF);
    axr(`MQF_ADDR_CTRL, {`MQF_RESP_OK, 32'h00000000});
    axw(8'h18, 32'hFFFFFFFF, 4'hF);
    for (int i = 0; i < 6; i++)
      run(i);
    repeat (4) @(posedge aclk);
    results();
  end

  // Whole run needs well under a thousand cycles; allow thirty thousand
  initial
  begin
    #3000000;
    mismatches++;
    results();
  end
endmodule
